// [hdl/fp_state_and_soft_interrupt_regs.sv]
// Function
// - FP ops allowed only when fpu_enable_flag and global_fp_enable are both set.
// - Nonprivileged software reads and writes fp_reg_state without privilege trap.
// - upper_dirty set whenever an upper-half FP register is modified.
// - lower_dirty set whenever a lower-half FP register is modified.
// - Dirty bits cleared only by an explicit software write.
// - Dirty bits may be set pessimistically on any executing fp_operation.
// - fp_operation that raises fpu_off_trap leaves dirty bits unchanged.
// - media_aux_status is nonprivileged read/write and feeds media instructions.
// - media_aux_status access traps fpu_off_trap, unperformed, when FPU disabled.
// - Nonprivileged access to pending_sw_interrupts, or write to its ports, raises priv_op_fault.
// - level14 request when tick_match_flag or bit 14 is set.
// - tick_match_flag and bit 14 stored independently.
// - Set port ORs write data 16:0 into pending_sw_interrupts.
// - Clear port clears bits where write data 16:0 is one.
// - Set and clear ports ignore write data bits 63:17.
// - Set port privileged, write-only; nonprivileged write raises priv_op_fault.
// - Clear port privileged, write-only; nonprivileged write raises priv_op_fault.
// - tick_match_flag is bit 16, set by hardware on tick compare match.
`default_nettype none
module fp_state_and_soft_interrupt_regs
	import anc_state_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire anc_state_pkg::anc_req_t anc_req,
	input wire anc_state_pkg::fp_op_t fp_op,
	input wire logic global_fp_enable,
	input wire logic tick_match,
	output anc_state_pkg::anc_rsp_t anc_rsp,
	output logic fp_op_trap,
	output logic fpu_enabled,
	output logic [anc_state_pkg::DATA_W-1:0] media_status_out,
	output logic [anc_state_pkg::SOFT_W-1:0] pending_out,
	output logic level14_interrupt
);
	import anc_state_pkg::*;

	logic [FPSTATE_W-1:0] fpstate_ff;
	logic [DATA_W-1:0] media_ff;
	logic [SOFT_W-1:0] soft_ff;
	anc_rsp_t rsp_ff;
	logic fp_trap_ff;
	logic lvl14_ff;

	wire access = anc_req.rd | anc_req.wr;
	wire fpu_on = fpstate_ff[FPU_ENABLE_BIT] & global_fp_enable;
	wire sel_fpstate = anc_req.idx == FP_REG_STATE_IDX;
	wire sel_media = anc_req.idx == MEDIA_AUX_STATUS_IDX;
	wire sel_set = anc_req.idx == PENDING_INT_SET_IDX;
	wire sel_clr = anc_req.idx == PENDING_INT_CLEAR_IDX;
	wire sel_soft = anc_req.idx == PENDING_SW_INT_IDX;

	// Set/clear ports are write-only, so a read of them counts as unmapped
	wire soft_access = sel_soft | ((sel_set | sel_clr) & anc_req.wr);
	wire priv_fault = access & soft_access & ~anc_req.priv;
	wire media_trap = access & sel_media & ~fpu_on;
	wire soft_ok = anc_req.wr & anc_req.priv;

	wire wr_fpstate = anc_req.wr & sel_fpstate;
	wire wr_media = anc_req.wr & sel_media & fpu_on;
	wire wr_soft = soft_ok & sel_soft;
	wire wr_set = soft_ok & sel_set;
	wire wr_clr = soft_ok & sel_clr;

	// Only bits 16:0 of the port data are looked at
	wire [SOFT_W-1:0] port_bits = anc_req.wdata[SOFT_W-1:0];

	wire fp_trap = fp_op.fp_op & ~fpu_on;
	wire fp_ok = fp_op.fp_op & fpu_on;
	// Dirty set only on real F register writes; not pessimistic, which is allowed
	wire set_upper = fp_ok & fp_op.wr_upper;
	wire set_lower = fp_ok & fp_op.wr_lower;

	wire [FPSTATE_W-1:0] fpstate_sw = wr_fpstate ? anc_req.wdata[FPSTATE_W-1:0] : fpstate_ff;
	wire [FPSTATE_W-1:0] dirty_set = {1'b0, set_upper, set_lower};
	// A dirty event in the same cycle as a software write still lands
	wire [FPSTATE_W-1:0] nxt_fpstate = fpstate_sw | dirty_set;

	wire [DATA_W-1:0] nxt_media = wr_media ? anc_req.wdata : media_ff;

	wire [SOFT_W-1:0] soft_sw = wr_soft ? port_bits :
		wr_set ? (soft_ff | port_bits) :
		wr_clr ? (soft_ff & ~port_bits) :
		soft_ff;
	wire [SOFT_W-1:0] tick_set = {tick_match, {(SOFT_W-1){1'b0}}};
	// Per-bit update keeps bit 14 and tick flag independent; hardware set wins
	wire [SOFT_W-1:0] nxt_soft = soft_sw | tick_set;

	wire nxt_lvl14 = nxt_soft[TICK_MATCH_BIT] | nxt_soft[LEVEL14_BIT];

	wire [DATA_W-1:0] rd_val = sel_fpstate ? {{(DATA_W-FPSTATE_W){1'b0}}, fpstate_ff} :
		sel_media ? media_ff :
		sel_soft ? {{(DATA_W-SOFT_W){1'b0}}, soft_ff} :
		{DATA_W{1'b0}};

	anc_rsp_t nxt_rsp;
	assign nxt_rsp.valid = access;
	assign nxt_rsp.fpu_off_trap = media_trap;
	assign nxt_rsp.priv_op_fault = priv_fault;
	assign nxt_rsp.rdata = (anc_req.rd & ~media_trap & ~priv_fault) ? rd_val : {DATA_W{1'b0}};

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fpstate_ff <= FP_REG_STATE_RST;
			media_ff <= MEDIA_AUX_STATUS_RST;
			soft_ff <= PENDING_SW_INT_RST;
			rsp_ff <= '0;
			fp_trap_ff <= 1'b0;
			lvl14_ff <= 1'b0;
		end else begin
			fpstate_ff <= nxt_fpstate;
			media_ff <= nxt_media;
			soft_ff <= nxt_soft;
			rsp_ff <= nxt_rsp;
			fp_trap_ff <= fp_trap;
			lvl14_ff <= nxt_lvl14;
		end
	end

	assign anc_rsp = rsp_ff;
	assign fp_op_trap = fp_trap_ff;
	assign fpu_enabled = fpstate_ff[FPU_ENABLE_BIT];
	assign media_status_out = media_ff;
	assign pending_out = soft_ff;
	assign level14_interrupt = lvl14_ff;
endmodule
`default_nettype wire

// [hdl/anc_state_pkg.sv]
`default_nettype none
package anc_state_pkg;
	localparam int DATA_W = 64;
	localparam int ADDR_W = 5;
	localparam int SOFT_W = 17;
	localparam int FPSTATE_W = 3;

	// Ancillary register numbers
	localparam logic [ADDR_W-1:0] FP_REG_STATE_IDX = 5'h06;
	localparam logic [ADDR_W-1:0] MEDIA_AUX_STATUS_IDX = 5'h13;
	localparam logic [ADDR_W-1:0] PENDING_INT_SET_IDX = 5'h14;
	localparam logic [ADDR_W-1:0] PENDING_INT_CLEAR_IDX = 5'h15;
	localparam logic [ADDR_W-1:0] PENDING_SW_INT_IDX = 5'h16;

	// Field positions
	localparam int FPU_ENABLE_BIT = 2;
	localparam int UPPER_DIRTY_BIT = 1;
	localparam int LOWER_DIRTY_BIT = 0;
	localparam int TICK_MATCH_BIT = 16;
	localparam int LEVEL14_BIT = 14;

	// Reset values
	localparam logic [FPSTATE_W-1:0] FP_REG_STATE_RST = 3'h0;
	localparam logic [SOFT_W-1:0] PENDING_SW_INT_RST = 17'h00000;
	localparam logic [DATA_W-1:0] MEDIA_AUX_STATUS_RST = 64'h0000000000000000;

	typedef struct packed {
		logic rd;
		logic wr;
		logic priv;
		logic [ADDR_W-1:0] idx;
		logic [DATA_W-1:0] wdata;
	} anc_req_t;

	typedef struct packed {
		logic fp_op;
		logic wr_upper;
		logic wr_lower;
	} fp_op_t;

	typedef struct packed {
		logic valid;
		logic fpu_off_trap;
		logic priv_op_fault;
		logic [DATA_W-1:0] rdata;
	} anc_rsp_t;
endpackage
`default_nettype wire

// [test/fp_pipe_model.sv]
`default_nettype none
module fp_pipe_model (
	input wire logic [1:0] fp_cmd,
	output anc_state_pkg::fp_op_t fp_op
);
	// Nonzero command issues one fp op for the flagged halves
	assign fp_op = {|fp_cmd, fp_cmd};
endmodule
`default_nettype wire

// [test/fp_regs_chk.sv]
`default_nettype none
module fp_regs_chk
	import anc_state_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire anc_state_pkg::anc_req_t anc_req,
	input wire anc_state_pkg::fp_op_t fp_op,
	input wire logic global_fp_enable,
	input wire logic tick_match,
	input wire anc_state_pkg::anc_rsp_t anc_rsp,
	input wire logic fp_op_trap,
	input wire logic fpu_enabled,
	input wire logic [anc_state_pkg::SOFT_W-1:0] pending_out,
	input wire logic level14_interrupt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	wire logic acc = anc_req.rd | anc_req.wr;
	wire logic off = !(fpu_enabled & global_fp_enable);
	wire logic [ADDR_W-1:0] ix = anc_req.idx;
	wire logic [SOFT_W-1:0] wd = anc_req.wdata[SOFT_W-1:0];
	// Tick excluded: it may legally win over a clear
	wire logic wp = anc_req.wr & anc_req.priv & !tick_match;
	answer_a: assert property (acc |=> anc_rsp.valid) else $error("no answer");
	fp_trap_a: assert property (fp_op.fp_op & off |=> fp_op_trap) else $error("no fp trap");
	media_off_a: assert property (acc & off & ix == MEDIA_AUX_STATUS_IDX |=> anc_rsp.fpu_off_trap)
		else $error("no media trap");
	priv_a: assert property (acc & !anc_req.priv & ix == PENDING_SW_INT_IDX |=> anc_rsp.priv_op_fault)
		else $error("no fault");
	port_priv_a: assert property (anc_req.wr & !anc_req.priv & ix[4:1] == 4'hA |=> anc_rsp.priv_op_fault)
		else $error("no port fault");
	level14_a: assert property (level14_interrupt == (pending_out[16] | pending_out[14]))
		else $error("level14 wrong");
	tick_a: assert property (tick_match |=> pending_out[16]) else $error("tick lost");
	set_a: assert property (wp & ix == PENDING_INT_SET_IDX |=> (pending_out & $past(wd)) == $past(wd))
		else $error("set failed");
	clear_a: assert property (wp & ix == PENDING_INT_CLEAR_IDX |=> !(|(pending_out & $past(wd))))
		else $error("clear failed");
endmodule
bind fp_state_and_soft_interrupt_regs fp_regs_chk chk (.sys_clk, .arst_n, .anc_req, .fp_op, .global_fp_enable,
	.tick_match, .anc_rsp, .fp_op_trap, .fpu_enabled, .pending_out, .level14_interrupt);
`default_nettype wire

// [test/fp_state_and_soft_interrupt_regs_test.sv]
`default_nettype none
module fp_state_and_soft_interrupt_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import anc_state_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic global_fp_enable = 1'b1;
	logic tick_match = 1'b0;
	logic [1:0] fp_cmd = 2'h0;
	anc_req_t anc_req = '0;
	fp_op_t fp_op;
	anc_rsp_t anc_rsp, r;
	logic fp_op_trap, level14_interrupt, fpu_enabled;
	logic [63:0] media_status_out;
	logic [SOFT_W-1:0] pending_out;
	int miscompares = 0;
	int tests_run = 0;
	always #10 sys_clk = ~sys_clk;
	fp_pipe_model pipe (.fp_cmd, .fp_op);
	fp_state_and_soft_interrupt_regs dut (.sys_clk, .arst_n, .anc_req, .fp_op, .global_fp_enable, .tick_match,
		.anc_rsp, .fp_op_trap, .fpu_enabled, .media_status_out, .pending_out, .level14_interrupt);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	// One request, tick and fp command taken at one edge; answer read a cycle on
	task automatic acc(input logic [2:0] k, input logic [4:0] ix, input logic [63:0] d, input logic tk = 1'b0,
		input logic [1:0] fc = 2'h0);
		@(posedge sys_clk);
		anc_req <= '{k[2], k[1], k[0], ix, d};
		tick_match <= tk;
		fp_cmd <= fc;
		@(posedge sys_clk);
		anc_req <= '0;
		tick_match <= 1'b0;
		fp_cmd <= 2'h0;
		#1 r = anc_rsp;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		arst_n <= 1'b1;
		acc(3'h2, 5'h06, 64'h4);
		chk(r.valid, 1'b1);
		acc(3'h0, 5'h00, 64'h0, 1'b0, 2'h2);
		acc(3'h0, 5'h00, 64'h0, 1'b0, 2'h1);
		acc(3'h4, 5'h06, 64'h0);
		chk(r.rdata, 64'h7);
		acc(3'h2, 5'h06, 64'h4);
		acc(3'h2, 5'h13, 64'hA5A5_0F0F_C3C3_1234);
		@(posedge sys_clk) global_fp_enable <= 1'b0;
		acc(3'h0, 5'h00, 64'h0, 1'b0, 2'h3);
		chk(fp_op_trap, 1'b1);
		acc(3'h2, 5'h13, 64'h0);
		chk(r.fpu_off_trap, 1'b1);
		@(posedge sys_clk) global_fp_enable <= 1'b1;
		acc(3'h4, 5'h06, 64'h0);
		chk(r.rdata, 64'h4);
		chk(fpu_enabled, 1'b1);
		acc(3'h4, 5'h13, 64'h0);
		chk(r.rdata, 64'hA5A5_0F0F_C3C3_1234);
		chk(media_status_out, 64'hA5A5_0F0F_C3C3_1234);
		$display("fp state test done");
		acc(3'h2, 5'h14, 64'h1);
		chk({r.priv_op_fault, pending_out}, 18'h20000);
		acc(3'h2, 5'h15, 64'h0);
		chk(r.priv_op_fault, 1'b1);
		acc(3'h3, 5'h14, 64'hFFFF_FFFF_FFFE_4001);
		chk({level14_interrupt, pending_out}, 18'h24001);
		acc(3'h0, 5'h00, 64'h0, 1'b1);
		chk(pending_out, 17'h14001);
		acc(3'h3, 5'h15, 64'hFFFF_FFFF_FFFD_4000, 1'b1);
		chk({level14_interrupt, pending_out}, 18'h30001);
		acc(3'h3, 5'h15, 64'h1_0000);
		acc(3'h5, 5'h16, 64'h0);
		chk({level14_interrupt, r.rdata[16:0]}, 18'h00001);
		$display("interrupt test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
